// ===== rtl/mxcfg_pkg.sv
package mxcfg_pkg;

  // register address and data widths
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [9:0] QN_OFFSET_TRIM_ADDR       = 10'h109;
  localparam logic [9:0] DETECTOR_SPAN_ADDR        = 10'h10c;
  localparam logic [9:0] GAIN_LOOP_REFERENCE_ADDR  = 10'h10d;
  localparam logic [9:0] INPUT_TERMINATION_ADDR    = 10'h115;
  localparam logic [9:0] HARMONIC_TRAP_ADDR        = 10'h116;
  localparam logic [9:0] READBACK_PAGE_ADDR        = 10'h117;
  localparam logic [9:0] RESISTOR_CALIBRATION_ADDR = 10'h119;

  // reset values
  localparam logic [7:0] QN_OFFSET_TRIM_RST       = 8'h7f;
  localparam logic [7:0] DETECTOR_SPAN_RST        = 8'h08;
  localparam logic [7:0] GAIN_LOOP_REFERENCE_RST  = 8'h69;
  localparam logic [7:0] INPUT_TERMINATION_RST    = 8'h08;
  localparam logic [7:0] HARMONIC_TRAP_RST        = 8'h00;
  localparam logic [7:0] READBACK_PAGE_RST        = 8'h4c;
  localparam logic [7:0] RESISTOR_CALIBRATION_RST = 8'h08;

  // field positions
  localparam int unsigned TERM_BIT      = 7;
  localparam int unsigned PAGE_MSB      = 7;
  localparam int unsigned PAGE_LSB      = 6;
  localparam int unsigned CAL_START_BIT = 5;
  localparam int unsigned CAL_EN_BIT    = 4;

  // page codes
  localparam logic [1:0] PAGE_SYNTH = 2'h0;
  localparam logic [1:0] PAGE_MIXER = 2'h1;

  // section bounds
  localparam logic [9:0] SYNTH_LO  = 10'h010;
  localparam logic [9:0] SYNTH_HI  = 10'h07c;
  localparam logic [9:0] MIX_A_LO  = 10'h000;
  localparam logic [9:0] MIX_A_HI  = 10'h00d;
  localparam logic [9:0] MIX_B_LO  = 10'h100;
  localparam logic [9:0] MIX_B_HI  = 10'h119;

endpackage : mxcfg_pkg

// ===== rtl/mxcfg_reg8.sv
`timescale 1ns/10ps
`default_nettype none

// one 8-bit configuration register with reset value
module mxcfg_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // write side
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_data_in,
  // stored value
  output logic      [7:0] q_out
);

  logic [7:0] val_ff;

  // every bit is writable, reserved bits too
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      val_ff <= RST_VAL;
    end else if (wr_en_in) begin
      val_ff <= wr_data_in;
    end
  end

  assign q_out = val_ff;

endmodule : mxcfg_reg8

`default_nettype wire

// ===== rtl/mxcfg_regs.sv
// How it works
// - writable 7-bit negative lane trim, reset 0x7F
// - 7-bit detector span field, reset 0x8
// - 7-bit gain loop reference, reset 0x69
// - bit 7 selects input termination, reset 0
// - 4-bit harmonic trap cutoff select, reset 0
// - page 0 reads synthesizer section
// - page 1, reset, reads mixer section
// - bit 5 starts resistor calibration
// - bit 4 enables resistor calibration circuitry
// - page register resets to 0x4C
// - calibration register resets to 0x08
`timescale 1ns/10ps
`default_nettype none

module mxcfg_regs (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // register access from the serial port logic
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  input  wire logic [9:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  // synthesizer section read data, same clock
  input  wire logic [7:0] synth_rd_data_in,
  // read answer
  output logic      [7:0] rd_data_out,
  output logic            rd_valid_out,
  output logic            rd_hit_out,
  // analog controls
  output logic      [6:0] neg_quad_lane_trim_out,
  output logic      [6:0] detector_span_out,
  output logic      [6:0] gain_loop_reference_out,
  output logic            if_term_out,
  output logic      [3:0] harmonic_trap_out,
  output logic      [1:0] page_sel_out,
  output logic            cal_start_out,
  output logic            cal_en_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  localparam int unsigned NREG = 7;

  // address to register index, NREG when unmapped
  function automatic logic [2:0] reg_index(input logic [9:0] a);
    unique case (a)
      mxcfg_pkg::QN_OFFSET_TRIM_ADDR:       reg_index = 3'h0;
      mxcfg_pkg::DETECTOR_SPAN_ADDR:        reg_index = 3'h1;
      mxcfg_pkg::GAIN_LOOP_REFERENCE_ADDR:  reg_index = 3'h2;
      mxcfg_pkg::INPUT_TERMINATION_ADDR:    reg_index = 3'h3;
      mxcfg_pkg::HARMONIC_TRAP_ADDR:        reg_index = 3'h4;
      mxcfg_pkg::READBACK_PAGE_ADDR:        reg_index = 3'h5;
      mxcfg_pkg::RESISTOR_CALIBRATION_ADDR: reg_index = 3'h6;
      default:                              reg_index = 3'h7;
    endcase
  endfunction : reg_index

  // inclusive range check, used for both sections
  function automatic logic in_range(input logic [9:0] a, input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  localparam logic [7:0] RST_TAB [NREG] = '{
    mxcfg_pkg::QN_OFFSET_TRIM_RST,
    mxcfg_pkg::DETECTOR_SPAN_RST,
    mxcfg_pkg::GAIN_LOOP_REFERENCE_RST,
    mxcfg_pkg::INPUT_TERMINATION_RST,
    mxcfg_pkg::HARMONIC_TRAP_RST,
    mxcfg_pkg::READBACK_PAGE_RST,
    mxcfg_pkg::RESISTOR_CALIBRATION_RST
  };

  logic [2:0] wr_idx;
  logic [7:0] reg_q [NREG];

  assign wr_idx = reg_index(addr_in);

  // writes land whatever the page is
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      mxcfg_reg8 #(
        .RST_VAL (RST_TAB[gi])
      ) u_reg (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (wr_en_in && (wr_idx == 3'(gi))),
        .wr_data_in  (wr_data_in),
        .q_out       (reg_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path, page steers which section answers

  logic [1:0] page;
  logic       synth_hit;
  logic       mix_hit;
  logic [7:0] nxt_rd_data;
  logic       nxt_rd_hit;

  assign page      = reg_q[5][mxcfg_pkg::PAGE_MSB:mxcfg_pkg::PAGE_LSB];
  assign synth_hit = in_range(addr_in, mxcfg_pkg::SYNTH_LO, mxcfg_pkg::SYNTH_HI);
  assign mix_hit   = in_range(addr_in, mxcfg_pkg::MIX_A_LO, mxcfg_pkg::MIX_A_HI) ||
                     in_range(addr_in, mxcfg_pkg::MIX_B_LO, mxcfg_pkg::MIX_B_HI);

  // lower mixer registers live elsewhere, so gaps inside the section read zero
  always_comb begin
    nxt_rd_data = 8'h00;
    nxt_rd_hit  = 1'b0;
    if (page == mxcfg_pkg::PAGE_SYNTH) begin
      if (synth_hit) begin
        nxt_rd_data = synth_rd_data_in;
        nxt_rd_hit  = 1'b1;
      end
    end else if (page == mxcfg_pkg::PAGE_MIXER) begin
      if (mix_hit) begin
        nxt_rd_hit = 1'b1;
        if (wr_idx != 3'h7) begin
          nxt_rd_data = reg_q[wr_idx];
        end
      end
    end
  end

  logic [7:0] rd_data_ff;
  logic       rd_valid_ff;
  logic       rd_hit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read answer, one flop per concern, all one cycle after the request

  // valid pulse: exactly one cycle per accepted read strobe
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en_in;
    end
  end

  // data is forced to zero outside an answer so a stale byte never lingers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_ff <= 8'h00;
    end else if (rd_en_in) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // hit tells the host whether the selected page owns the address;
  // a miss still answers, so the host never waits on an unmapped read
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_hit_ff <= 1'b0;
    end else begin
      rd_hit_ff <= rd_en_in && nxt_rd_hit;
    end
  end

  assign rd_data_out  = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
  assign rd_hit_out   = rd_hit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // field outputs, taken straight from the register flops

  assign neg_quad_lane_trim_out  = reg_q[0][6:0];
  assign detector_span_out       = reg_q[1][6:0];
  assign gain_loop_reference_out = reg_q[2][6:0];
  assign if_term_out             = reg_q[3][mxcfg_pkg::TERM_BIT];
  assign harmonic_trap_out       = reg_q[4][3:0];
  assign page_sel_out            = page;
  assign cal_start_out           = reg_q[6][mxcfg_pkg::CAL_START_BIT];
  assign cal_en_out              = reg_q[6][mxcfg_pkg::CAL_EN_BIT];

endmodule : mxcfg_regs

`default_nettype wire

// ===== verif/mxcfg_props.sv
`timescale 1ns/10ps
`default_nettype none
// sees only the register block ports
module mxcfg_props (
  input wire logic       core_clk_in, rst_in, wr_en_in, rd_en_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] wr_data_in, synth_rd_data_in, rd_data_out,
  input wire logic       rd_valid_out, rd_hit_out, if_term_out, cal_start_out, cal_en_out,
  input wire logic [6:0] neg_quad_lane_trim_out, detector_span_out, gain_loop_reference_out,
  input wire logic [3:0] harmonic_trap_out,
  input wire logic [1:0] page_sel_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // field outputs follow the written byte one cycle later
  AST_TRIM_WR: assert property (wr_en_in && addr_in == 10'h109 |=>
    {1'b0, neg_quad_lane_trim_out} == ($past(wr_data_in) & 8'h7f)) else $error("trim write lost");
  AST_SPAN_WR: assert property (wr_en_in && addr_in == 10'h10c |=>
    {1'b0, detector_span_out} == ($past(wr_data_in) & 8'h7f)) else $error("span write lost");
  AST_REF_WR: assert property (wr_en_in && addr_in == 10'h10d |=>
    {1'b0, gain_loop_reference_out} == ($past(wr_data_in) & 8'h7f))
    else $error("reference write lost");
  AST_TERM_WR: assert property (wr_en_in && addr_in == 10'h115 |=>
    {if_term_out, 7'h0} == ($past(wr_data_in) & 8'h80)) else $error("term write lost");
  AST_TRAP_WR: assert property (wr_en_in && addr_in == 10'h116 |=>
    {4'h0, harmonic_trap_out} == ($past(wr_data_in) & 8'h0f)) else $error("trap write lost");
  AST_PAGE_WR: assert property (wr_en_in && addr_in == 10'h117 |=>
    {page_sel_out, 6'h0} == ($past(wr_data_in) & 8'hc0)) else $error("page write lost");
  AST_CAL_WR: assert property (wr_en_in && addr_in == 10'h119 |=>
    {cal_start_out, cal_en_out} == $past(wr_data_in[5:4])) else $error("cal write lost");
  // reset levels seen on the cycle after any reset edge
  AST_RST_VAL: assert property (disable iff (1'b0) rst_in |=>
    neg_quad_lane_trim_out == 7'h7f && harmonic_trap_out == 4'h0 && page_sel_out == 2'h1
    && !if_term_out && !cal_start_out && !cal_en_out && !rd_valid_out)
    else $error("bad reset state");
  // page decides which section answers
  AST_SYN_RD: assert property (rd_en_in && page_sel_out == 2'h0 && addr_in >= 10'h010
    && addr_in <= 10'h07c |=> rd_hit_out && rd_data_out == $past(synth_rd_data_in))
    else $error("synth read wrong");
  AST_MIX_RD: assert property (rd_en_in && page_sel_out == 2'h1 && (addr_in <= 10'h00d
    || addr_in inside {[10'h100:10'h119]}) |=> rd_valid_out && rd_hit_out)
    else $error("mixer read missed");
  AST_IDLE: assert property (!rd_valid_out |-> rd_data_out == 8'h0 && !rd_hit_out)
    else $error("read data outside answer");
endmodule : mxcfg_props
bind mxcfg_regs mxcfg_props u_props (.core_clk_in, .rst_in, .wr_en_in, .rd_en_in, .addr_in,
  .wr_data_in, .synth_rd_data_in, .rd_data_out, .rd_valid_out, .rd_hit_out, .if_term_out,
  .cal_start_out, .cal_en_out, .neg_quad_lane_trim_out, .detector_span_out,
  .gain_loop_reference_out, .harmonic_trap_out, .page_sel_out);
`default_nettype wire

// ===== verif/mxcfg_synth_model.sv
`timescale 1ns/10ps
`default_nettype none
// synthesizer section stand-in
module mxcfg_synth_model (
  input  wire logic [9:0] addr_in,
  output logic      [7:0] synth_rd_data_out
);
  // address-keyed pattern so a stale or misrouted fetch shows
  assign synth_rd_data_out = addr_in[7:0] ^ 8'h5a;
endmodule : mxcfg_synth_model
`default_nettype wire

// ===== verif/tb_mixer_config_registers.sv
`timescale 1ns/10ps
`default_nettype none
module tb_mixer_config_registers;
  logic       core_clk_in = 0, rst_in = 1, wr_en_in = 0, rd_en_in = 0;
  logic [9:0] addr_in = 10'h0;
  logic [7:0] wr_data_in = 8'h0, synth_rd_data_in, rd_data_out;
  logic       rd_valid_out, rd_hit_out, if_term_out, cal_start_out, cal_en_out;
  logic [6:0] neg_quad_lane_trim_out, detector_span_out, gain_loop_reference_out;
  logic [3:0] harmonic_trap_out;
  logic [1:0] page_sel_out;
  int         error_cnt = 0, compares = 0, cyc = 0;
  logic [9:0] adr [7] = '{10'h109, 10'h10c, 10'h10d, 10'h115, 10'h116, 10'h117, 10'h119};
  logic [7:0] rv [7] = '{8'h7f, 8'h08, 8'h69, 8'h08, 8'h00, 8'h4c, 8'h08};
  logic [7:0] wv [7] = '{8'h5f, 8'h2a, 8'h15, 8'h88, 8'h09, 8'h4c, 8'h38};

  mxcfg_regs u_dut (.core_clk_in, .rst_in, .wr_en_in, .rd_en_in, .addr_in, .wr_data_in,
    .synth_rd_data_in, .rd_data_out, .rd_valid_out, .rd_hit_out, .neg_quad_lane_trim_out,
    .detector_span_out, .gain_loop_reference_out, .if_term_out, .harmonic_trap_out,
    .page_sel_out, .cal_start_out, .cal_en_out);
  mxcfg_synth_model u_synth (.addr_in, .synth_rd_data_out(synth_rd_data_in));

  // clock and hang guard; a run needs about 100 cycles
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one idle cycle between strobes keeps each assignment to its own step
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk_in) wr_en_in = 1;
    addr_in = a;
    wr_data_in = d;
    @(negedge core_clk_in) wr_en_in = 0;
  endtask : wr

  task rd(input logic [9:0] a, input logic [7:0] e, input logic h);
    @(negedge core_clk_in) rd_en_in = 1;
    addr_in = a;
    @(negedge core_clk_in) rd_en_in = 0;
    chk({7'h0, rd_valid_out}, 8'h01);
    chk({7'h0, rd_hit_out}, {7'h0, h});
    chk(rd_data_out, e);
  endtask : rd

  task give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    repeat (2) @(negedge core_clk_in);
    rst_in = 0;
    for (int i = 0; i < 7; i++) rd(adr[i], rv[i], 1);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      wr(10'h116, i[7:0]);
      chk({4'h0, harmonic_trap_out}, i[7:0]);
    end
    for (int i = 0; i < 7; i++) wr(adr[i], wv[i]);
    for (int i = 0; i < 7; i++) rd(adr[i], wv[i], 1);
    chk({1'b0, neg_quad_lane_trim_out}, 8'h5f);
    chk({if_term_out, cal_start_out, cal_en_out, 5'h0}, 8'he0);
    chk({1'b0, detector_span_out}, 8'h2a);
    chk({1'b0, gain_loop_reference_out}, 8'h15);
    wr(10'h119, 8'h28);
    chk({6'h0, cal_start_out, cal_en_out}, 8'h02);
    wr(10'h119, 8'h18);
    chk({6'h0, cal_start_out, cal_en_out}, 8'h01);
    wr(10'h10a, 8'hff);
    rd(10'h10a, 8'h00, 1);
    $display("write test done");
    wr(10'h117, 8'h0c);
    rd(10'h020, 8'h7a, 1);
    rd(10'h07c, 8'h26, 1);
    rd(10'h07d, 8'h00, 0);
    rd(10'h109, 8'h00, 0);
    wr(10'h117, 8'h8c);
    rd(10'h020, 8'h00, 0);
    wr(10'h117, 8'h4c);
    rd(10'h117, 8'h4c, 1);
    rd(10'h00d, 8'h00, 1);
    rd(10'h00e, 8'h00, 0);
    rd(10'h11a, 8'h00, 0);
    $display("page test done");
    give_verdict();
  end
endmodule : tb_mixer_config_registers
`default_nettype wire
